// File: adcs_ana_model.sv
// comparator stand-in for the analog front end
// trial code from the sequencer, held input level set by the bench
`timescale 1ns/10ps
`include "adcs_map.vh"
module adcs_ana_model (
    input wire logic [`ADCS_RES_W-1:0] trial,
    input wire logic [`ADCS_RES_W-1:0] level,
    output logic comp
);
    assign comp = (level >= trial);
endmodule

// File: adcs_ctrl.v
// top of the converter control sequencer: parallel port, control byte,
// acquisition/conversion sequencing, power-down states, result holding
// pins are synchronous to mclk; analog comparator and DAC sit outside
`timescale 1ns/10ps
`include "adcs_map.vh"
module adcs_ctrl #(
    parameter INT_DIV = `ADCS_INT_DIV
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire conv_clk_in,
    input wire [`ADCS_CTL_W-1:0] data_in,
    output reg [`ADCS_RES_W-1:0] data_out_r,
    output reg data_oe_r,
    output reg done_n_r,
    input wire comp_in,
    output reg [`ADCS_RES_W-1:0] dac_code_r,
    output reg track_r,
    output reg [2:0] chan_sel_r,
    output reg input_pairing_sel_r,
    output reg standby_r,
    output reg shutdown_r
);
    localparam ST_IDLE = 4'h1;
    localparam ST_ACQI = 4'h2;
    localparam ST_ACQX = 4'h4;
    localparam ST_CONV = 4'h8;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [`ADCS_CTL_W-1:0] ctl_r;
    reg ext_clk_mode_r;
    reg wr_n_q_r;
    reg rd_n_q_r;
    reg cclk_q_r;
    reg [7:0] div_r;
    reg [1:0] acq_cnt_r;
    reg pd_pend_r;
    reg [1:0] pd_req_r;
    reg stale_r;
    reg sar_start;
    wire wr_rise;
    wire rd_fall;
    wire tick;
    wire cclk_rise;
    wire int_tick;
    wire [1:0] pd_bits;
    wire same_chan;
    wire sar_busy;
    wire sar_valid;
    wire sar_ready;
    wire [`ADCS_RES_W-1:0] sar_res;
    wire [`ADCS_RES_W-1:0] sar_trial;
    wire [`ADCS_RES_W-1:0] coded;
    wire fifo_valid;
    wire [`ADCS_RES_W-1:0] fifo_data;
    wire reading;
    wire fifo_in_ready;
    wire keep_res;

    // strobes count only while chip select is low
    assign wr_rise = !cs_n && wr_n && !wr_n_q_r;
    assign rd_fall = !cs_n && !rd_n && rd_n_q_r;
    assign reading = !cs_n && !rd_n;
    // a late result of an abandoned conversion is swallowed, not queued
    assign keep_res = sar_valid && !stale_r;
    assign sar_ready = stale_r || fifo_in_ready;
    assign cclk_rise = !cs_n && conv_clk_in && !cclk_q_r;
    assign int_tick = (div_r == 8'h00);
    assign tick = ext_clk_mode_r ? cclk_rise : int_tick;
    assign pd_bits = data_in[`ADCS_BIT_PWR_HI:`ADCS_BIT_PWR_LO];
    assign same_chan = (data_in[`ADCS_CHAN_HI:`ADCS_CHAN_LO] == ctl_r[`ADCS_CHAN_HI:`ADCS_CHAN_LO]);
    // unipolar straight binary, bipolar flips the top bit to two's complement
    assign coded = ctl_r[`ADCS_BIT_POL] ? sar_res : {~sar_res[`ADCS_RES_W-1], sar_res[`ADCS_RES_W-2:0]};

    adcs_sar u_sar (
        .clk(mclk),
        .rst(rst),
        .ce(ce),
        .start(sar_start),
        .tick(tick),
        .comp_in(comp_in),
        .res_ready(sar_ready),
        .trial_r(sar_trial),
        .busy_r(sar_busy),
        .res_valid_r(sar_valid),
        .res_r(sar_res)
    );

    adcs_fifo #(
        .WIDTH(`ADCS_RES_W),
        .DEPTH(`ADCS_FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk(mclk),
        .rst(rst),
        .ce(ce),
        .in_valid(keep_res),
        .in_ready(fifo_in_ready),
        .in_data(coded),
        .out_valid(fifo_valid),
        .out_ready(!reading),
        .out_data(fifo_data)
    );

    always @* begin
        state_nxt = state_r;
        sar_start = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (wr_rise) begin
                    state_nxt = data_in[`ADCS_BIT_ACQ] ? ST_ACQX : ST_ACQI;
                end
            end
            ST_ACQI: begin
                if (wr_rise) begin
                    state_nxt = data_in[`ADCS_BIT_ACQ] ? ST_ACQX : ST_ACQI;
                end else if (tick && acq_cnt_r == `ADCS_ACQ_TICKS - 2'h1) begin
                    state_nxt = ST_CONV;
                    sar_start = 1'b1;
                end
            end
            ST_ACQX: begin
                if (wr_rise) begin
                    if (!data_in[`ADCS_BIT_ACQ] && same_chan) begin
                        state_nxt = ST_CONV;
                        sar_start = 1'b1;
                    end else begin
                        state_nxt = data_in[`ADCS_BIT_ACQ] ? ST_ACQX : ST_ACQI;
                    end
                end
            end
            ST_CONV: begin
                // a new byte mid-conversion restarts acquisition
                if (wr_rise) begin
                    state_nxt = data_in[`ADCS_BIT_ACQ] ? ST_ACQX : ST_ACQI;
                end else if (!sar_busy) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ctl_r <= `ADCS_CTL_RESET;
            ext_clk_mode_r <= 1'b1;
            wr_n_q_r <= 1'b1;
            rd_n_q_r <= 1'b1;
            cclk_q_r <= 1'b0;
            div_r <= 8'h00;
            acq_cnt_r <= 2'h0;
            pd_pend_r <= 1'b0;
            pd_req_r <= `ADCS_PD_EXTCLK;
            stale_r <= 1'b0;
            data_out_r <= 12'h000;
            data_oe_r <= 1'b0;
            done_n_r <= 1'b1;
            dac_code_r <= 12'h000;
            track_r <= 1'b0;
            chan_sel_r <= 3'h0;
            input_pairing_sel_r <= 1'b0;
            standby_r <= 1'b0;
            shutdown_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            wr_n_q_r <= wr_n;
            rd_n_q_r <= rd_n;
            cclk_q_r <= conv_clk_in;
            div_r <= int_tick ? INT_DIV[7:0] - 8'h01 : div_r - 8'h01;
            if (wr_rise) begin
                ctl_r <= data_in;
                chan_sel_r <= data_in[`ADCS_CHAN_HI:`ADCS_CHAN_LO];
                input_pairing_sel_r <= data_in[`ADCS_BIT_PAIR];
                if (pd_bits == `ADCS_PD_INTCLK) begin
                    ext_clk_mode_r <= 1'b0;
                end else if (pd_bits == `ADCS_PD_EXTCLK) begin
                    ext_clk_mode_r <= 1'b1;
                end
                // power-down bytes leave the clock mode alone
                pd_pend_r <= (pd_bits == `ADCS_PD_SHUTDOWN) || (pd_bits == `ADCS_PD_STANDBY);
                pd_req_r <= pd_bits;
                standby_r <= 1'b0;
                shutdown_r <= 1'b0;
                acq_cnt_r <= 2'h0;
            end else if (state_r == ST_ACQI && tick) begin
                acq_cnt_r <= acq_cnt_r + 2'h1;
            end
            // power down only once the running conversion has finished
            if (!wr_rise && pd_pend_r && state_r == ST_IDLE && !sar_busy) begin
                pd_pend_r <= 1'b0;
                standby_r <= (pd_req_r == `ADCS_PD_STANDBY);
                shutdown_r <= (pd_req_r == `ADCS_PD_SHUTDOWN);
            end
            track_r <= (state_nxt == ST_ACQI) || (state_nxt == ST_ACQX);
            dac_code_r <= sar_trial;
            // a restart of the engine supersedes any abandoned conversion
            if (sar_start) begin
                stale_r <= 1'b0;
            end else if (wr_rise && sar_busy) begin
                stale_r <= 1'b1;
            end else if (sar_valid) begin
                stale_r <= 1'b0;
            end
            // holding register refreshes only outside a read, so a read sees stable data
            if (fifo_valid && !reading) begin
                data_out_r <= fifo_data;
            end
            data_oe_r <= reading;
            // the new result wins over a simultaneous write; a read holds it off and clears done
            if (fifo_valid && !reading) begin
                done_n_r <= 1'b0;
            end else if (rd_fall || wr_rise) begin
                done_n_r <= 1'b1;
            end
        end
    end
endmodule

// File: adcs_fifo.v
// synchronous FIFO carrying finished results toward the holding register
// single clock; push and pop both use valid/ready
`timescale 1ns/10ps
`include "adcs_map.vh"
module adcs_fifo #(
    parameter WIDTH = `ADCS_RES_W,
    parameter DEPTH = `ADCS_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem[rp_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (ce && push) begin
            mem[wp_r] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// File: adcs_map.vh
// constants for the parallel converter control sequencer
// included by every design file of the block; definitions only
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH
`define ADCS_CTL_W 8
`define ADCS_RES_W 12
`define ADCS_BIT_PWR_HI 7
`define ADCS_BIT_PWR_LO 6
`define ADCS_BIT_ACQ 5
`define ADCS_BIT_PAIR 4
`define ADCS_BIT_POL 3
`define ADCS_CHAN_HI 2
`define ADCS_CHAN_LO 0
`define ADCS_PD_SHUTDOWN 2'h0
`define ADCS_PD_STANDBY 2'h1
`define ADCS_PD_INTCLK 2'h2
`define ADCS_PD_EXTCLK 2'h3
`define ADCS_CTL_RESET 8'hC0
`define ADCS_ACQ_TICKS 2'h3
`define ADCS_CONV_TICKS 4'hD
`define ADCS_SAR_MSB 12'h800
`define ADCS_MCLK_NS 50
`define ADCS_INT_CONV_NS 3600
`define ADCS_INT_DIV ((`ADCS_INT_CONV_NS) / (13 * `ADCS_MCLK_NS))
`define ADCS_FIFO_DEPTH 16
`endif

// File: adcs_props.sv
// concurrent checks on the converter sequencer's pins
// bound to adcs_ctrl; every pin lives in the mclk domain
`timescale 1ns/10ps
`include "adcs_map.vh"
module adcs_props #(
    parameter INT_DIV = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic conv_clk_in,
    input wire logic [`ADCS_CTL_W-1:0] data_in,
    input wire logic [`ADCS_RES_W-1:0] data_out_r,
    input wire logic data_oe_r,
    input wire logic done_n_r,
    input wire logic comp_in,
    input wire logic [`ADCS_RES_W-1:0] dac_code_r,
    input wire logic track_r,
    input wire logic [2:0] chan_sel_r,
    input wire logic input_pairing_sel_r,
    input wire logic standby_r,
    input wire logic shutdown_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_write;
        ce && !cs_n && wr_n && !$past(wr_n);
    endsequence
    sequence s_read;
        ce && !cs_n && !rd_n;
    endsequence
    a_reset_done: assert property (disable iff (1'b0) rst && ce |=> done_n_r && !data_oe_r)
        else $error("done or drive wrong after reset");
    a_reset_power: assert property (disable iff (1'b0) rst && ce |=> !standby_r && !shutdown_r && !track_r)
        else $error("power state wrong after reset");
    a_cs_float: assert property (cs_n && ce |=> !data_oe_r)
        else $error("bus driven while deselected");
    a_read_drive: assert property (s_read |=> data_oe_r)
        else $error("bus not driven during read");
    a_write_track: assert property (s_write ##0 data_in[`ADCS_BIT_ACQ] |=> track_r)
        else $error("no tracking after write");
    a_write_clear: assert property (s_write |=> done_n_r)
        else $error("done not cleared by write");
    a_read_clear: assert property (s_read ##0 $past(rd_n) |=> done_n_r)
        else $error("done not cleared by read");
    a_hold_read: assert property (s_read ##1 s_read |-> $stable(data_out_r))
        else $error("result changed during read");
    a_wake_write: assert property (s_write ##0 (standby_r || shutdown_r) |=> !standby_r && !shutdown_r)
        else $error("write did not wake");
    a_pd_idle: assert property ((standby_r || shutdown_r) |-> !track_r)
        else $error("acquiring while powered down");
endmodule
bind adcs_ctrl adcs_props #(.INT_DIV(INT_DIV)) u_props (.mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .conv_clk_in(conv_clk_in), .data_in(data_in), .data_out_r(data_out_r),
    .data_oe_r(data_oe_r), .done_n_r(done_n_r), .comp_in(comp_in), .dac_code_r(dac_code_r),
    .track_r(track_r), .chan_sel_r(chan_sel_r), .input_pairing_sel_r(input_pairing_sel_r),
    .standby_r(standby_r), .shutdown_r(shutdown_r));

// File: adcs_sar.v
// successive-approximation engine: 12 decisions plus one closing tick
// comparator input is high when the held input is at or above the trial level
`timescale 1ns/10ps
`include "adcs_map.vh"
module adcs_sar (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire start,
    input wire tick,
    input wire comp_in,
    input wire res_ready,
    output reg [`ADCS_RES_W-1:0] trial_r,
    output reg busy_r,
    output reg res_valid_r,
    output reg [`ADCS_RES_W-1:0] res_r
);
    reg [`ADCS_RES_W-1:0] mask_r;
    reg [3:0] step_r;
    reg fresh_r;
    reg tick_pend_r;
    wire take;

    // dac copy lags the trial by one edge: a tick right after a trial change waits a cycle
    assign take = (tick || tick_pend_r) && !fresh_r;

    always @(posedge clk) begin
        if (rst) begin
            trial_r <= 12'h000;
            mask_r <= 12'h000;
            step_r <= 4'h0;
            busy_r <= 1'b0;
            res_valid_r <= 1'b0;
            res_r <= 12'h000;
            fresh_r <= 1'b0;
            tick_pend_r <= 1'b0;
        end else if (ce) begin
            fresh_r <= 1'b0;
            if (res_valid_r && res_ready) begin
                res_valid_r <= 1'b0;
            end
            if (start) begin
                trial_r <= `ADCS_SAR_MSB;
                mask_r <= `ADCS_SAR_MSB;
                step_r <= 4'h0;
                busy_r <= 1'b1;
                fresh_r <= 1'b1;
                tick_pend_r <= 1'b0;
            end else if (busy_r && fresh_r && tick) begin
                tick_pend_r <= 1'b1;
            end else if (busy_r && take) begin
                tick_pend_r <= 1'b0;
                // trial keeps the tested bit when comp_in is high, clears it otherwise, and sets the next lower bit
                if (step_r == `ADCS_CONV_TICKS - 4'h1) begin
                    // a full result path stalls the closing tick
                    if (!res_valid_r || res_ready) begin
                        busy_r <= 1'b0;
                        res_valid_r <= 1'b1;
                        res_r <= trial_r;
                    end
                end else begin
                    trial_r <= (comp_in ? trial_r : (trial_r & ~mask_r)) | (mask_r >> 1);
                    mask_r <= mask_r >> 1;
                    step_r <= step_r + 4'h1;
                    fresh_r <= 1'b1;
                end
            end
        end
    end
endmodule

// File: tb_top.sv
// self-checking bench for adcs_ctrl with the comparator model
// host bus driven from tasks; external conversion clock made here
`timescale 1ns/10ps
`include "adcs_map.vh"
module tb_top;
    logic mclk = 0, rst = 1, ce = 1, cs_n = 0, wr_n = 1, rd_n = 1, ext_run = 1, comp;
    logic [7:0] data_in = 8'h00;
    logic [11:0] vin = 12'h000, dout, dac, rv;
    logic [1:0] ck_div = 2'h0;
    logic oe, done_n, track, pair, stby, shdn;
    logic [2:0] chan;
    int err_count = 0, tests_run = 0, cyc = 0;
    // bench treats the reference as internal: 500us of settling at 50 ns per cycle
    localparam int REF_SETTLE = 10000;
    wire conv_clk = ext_run & ck_div[1];
    adcs_ctrl #(.INT_DIV(2)) dut_u (.mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .conv_clk_in(conv_clk), .data_in(data_in), .data_out_r(dout), .data_oe_r(oe),
        .done_n_r(done_n), .comp_in(comp), .dac_code_r(dac), .track_r(track), .chan_sel_r(chan),
        .input_pairing_sel_r(pair), .standby_r(stby), .shutdown_r(shdn));
    adcs_ana_model ana_u (.trial(dac), .level(vin), .comp(comp));
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        ck_div <= #1 ck_div + 2'h1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        @(posedge mclk);
        #1 wr_n = 0;
        data_in = b;
        @(posedge mclk);
        #1 wr_n = 1;
        @(posedge mclk);
        @(posedge mclk);
        #1;
    endtask
    task automatic rd;
        @(posedge mclk);
        #1 rd_n = 0;
        @(posedge mclk);
        @(posedge mclk);
        #1 rv = dout;
        chk({11'h0, oe}, 12'h1);
        rd_n = 1;
    endtask
    task automatic wdone;
        int n;
        n = 0;
        while (done_n !== 1'b0 && n < 400) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({11'h0, done_n}, 12'h0);
    endtask
    task automatic conv(input logic [7:0] b, input logic [11:0] v, input logic [11:0] e);
        vin = v;
        wr(b);
        wdone;
        rd;
        chk(rv, e);
        chk({11'h0, done_n}, 12'h1);
    endtask
    task automatic t_codes;
        conv(8'hC8, 12'hABC, 12'hABC);
        conv(8'hC5, 12'h123, 12'h923);
        conv(8'hDB, 12'hFFF, 12'hFFF);
        chk({8'h0, pair, chan}, 12'h00B);
        conv(8'h8E, 12'h5A5, 12'h5A5);
        conv(8'h8F, 12'h000, 12'h000);
        $display("codes done");
    endtask
    task automatic t_cs;
        cs_n = 1;
        rd_n = 0;
        wr(8'hE8);
        chk({11'h0, oe}, 12'h0);
        chk({8'h0, track, chan}, 12'h007);
        rd_n = 1;
        cs_n = 0;
        $display("deselect done");
    endtask
    task automatic t_power;
        ext_run = 0;
        wr(8'h48);
        wdone;
        repeat (4) @(posedge mclk);
        #1 chk({11'h0, stby}, 12'h1);
        ext_run = 1;
        conv(8'hC8, 12'h7FF, 12'h7FF);
        chk({11'h0, stby}, 12'h0);
        wr(8'h08);
        chk({11'h0, shdn}, 12'h0);
        wdone;
        repeat (4) @(posedge mclk);
        #1 chk({11'h0, shdn}, 12'h1);
        wr(8'hC8);
        chk({11'h0, shdn}, 12'h0);
        repeat (REF_SETTLE) @(posedge mclk);
        #1 conv(8'hC8, 12'h001, 12'h001);
        $display("power done");
    endtask
    task automatic t_acq;
        wr(8'hEA);
        repeat (40) @(posedge mclk);
        #1 chk({10'h0, track, done_n}, 12'h3);
        conv(8'hCA, 12'h3C3, 12'h3C3);
        $display("acquisition done");
    endtask
    task automatic t_fast;
        vin = 12'h456;
        wr(8'hC8);
        wdone;
        vin = 12'hBA9;
        wr(8'hC8);
        rd;
        chk(rv, 12'h456);
        wdone;
        rd;
        chk(rv, 12'hBA9);
        $display("overlap done");
    endtask
    task automatic t_freeze;
        vin = 12'h6B2;
        wr(8'hCC);
        ce = 0;
        repeat (30) @(posedge mclk);
        #1 chk({10'h0, track, done_n}, 12'h3);
        ce = 1;
        wdone;
        rd;
        chk(rv, 12'h6B2);
        $display("freeze done");
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst = 0;
        @(posedge mclk);
        #1 chk({7'h0, oe, done_n, stby, shdn, track}, 12'h008);
        repeat (REF_SETTLE) @(posedge mclk);
        #1 t_codes;
        t_cs;
        t_power;
        t_acq;
        t_fast;
        t_freeze;
        print_verdict;
    end
endmodule
